// file: hdl/vtpa_apb_regs.sv
`timescale 1ns/1ps
`include "vtpa_regs.svh"
module vtpa_apb_regs import vtpa_pkg::*; (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  vtpa_cfg_if.regs         cfg
);
  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic [31:0] ctrl_q;
  logic [7:0]  count_q;
  wire  setup    = psel_in & ~penable_in;
  wire  access   = psel_in & penable_in & pready_out;
  wire  hit_ctrl = (paddr_in == `VTPA_CTRL_OFS);
  wire  hit_cnt  = (paddr_in == `VTPA_COUNT_OFS);
  wire  hit_stat = (paddr_in == `VTPA_STAT_OFS);
  wire  hit_any  = hit_ctrl | hit_cnt | hit_stat;
  wire [31:0] rd_mux = hit_ctrl ? ctrl_q :
                       hit_cnt  ? {24'h0, count_q} :
                       hit_stat ? {23'h0, cfg.busy, cfg.sync_errs} : 32'h0;
  // reserved payload codes never stored, the old code stays
  wire  pt_ok = (pwdata_in & `VTPA_PT_MASK) <= `VTPA_PT_MAX;
  wire [31:0] ctrl_d = pt_ok ? pwdata_in :
                       (pwdata_in & ~`VTPA_PT_MASK) | (ctrl_q & `VTPA_PT_MASK);
  // zero packets per frame would only close a frame after 256 packets
  wire [7:0] count_d = (pwdata_in[7:0] == 8'h00) ? `VTPA_COUNT_RST : pwdata_in[7:0];
  assign cfg.ctrl       = ctrl_q;
  assign cfg.ts_per_pkt = count_q;

  // ----------------------------------------
  // registers and answer
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_q      <= `VTPA_CTRL_RST;
      count_q     <= `VTPA_COUNT_RST;
      prdata_out  <= 32'h0;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= setup;                 // one wait-free access cycle
      pslverr_out <= setup & ~hit_any;
      if (setup) prdata_out <= rd_mux;
      if (access && pwrite_in && hit_ctrl) ctrl_q <= ctrl_d;
      if (access && pwrite_in && hit_cnt) count_q <= count_d;
    end
  end

  chk_apb_ready: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    setup |=> pready_out ##1 !pready_out) else $error("apb ready not one cycle");
endmodule // vtpa_apb_regs

// file: hdl/vtpa_if.sv
`timescale 1ns/1ps
// ----------------------------------------
// configuration between regs and core
// ----------------------------------------
interface vtpa_cfg_if;
  logic [31:0] ctrl;
  logic [7:0]  ts_per_pkt;
  logic [7:0]  sync_errs;
  logic        busy;
  modport regs (output ctrl, ts_per_pkt, input sync_errs, busy);
  modport core (input ctrl, ts_per_pkt, output sync_errs, busy);
endinterface // vtpa_cfg_if

// ----------------------------------------
// packed words from byte packer
// ----------------------------------------
interface vtpa_word_if;
  logic [15:0] word;
  logic        valid;
  logic        take;
  logic        first;
  logic        last;
  logic [47:0] rel;
  logic [63:0] abs;
  logic        sync_err;
  modport src (output word, valid, first, last, rel, abs, sync_err, input take);
  modport snk (input word, valid, first, last, rel, abs, sync_err, output take);
endinterface // vtpa_word_if

// file: hdl/vtpa_pkg.sv
package vtpa_pkg;
  // ----------------------------------------
  // assembler states
  // ----------------------------------------
  typedef enum logic [2:0] {S_IDLE, S_CW_LO, S_CW_HI, S_NEXT, S_STAMP, S_DATA} vtpa_state_t;

  // two stream bytes into one word
  function automatic logic [15:0] vtpa_pair(input logic [7:0] early, input logic [7:0] late, input logic big);
    return big ? {late, early} : {early, late};
  endfunction

  // one half of a long word
  function automatic logic [15:0] vtpa_half(input logic [31:0] lw, input logic hi);
    return hi ? lw[31:16] : lw[15:0];
  endfunction
endpackage

// file: hdl/vtpa_regs.svh
`ifndef VTPA_REGS_SVH
`define VTPA_REGS_SVH

// ----------------------------------------
// stream constants
// ----------------------------------------
`define VTPA_SYNC        8'h47
`define VTPA_IDX_ZERO    8'h00
`define VTPA_IDX_ONE     8'h01
`define VTPA_TS_LAST     8'hBB
`define VTPA_WORDS_LAST  7'h5D
`define VTPA_STAMP_LAST  2'h3
`define VTPA_ERR_MAX     8'hFF

// ----------------------------------------
// register map and fields
// ----------------------------------------
`define VTPA_CTRL_OFS    8'h00
`define VTPA_COUNT_OFS   8'h04
`define VTPA_STAT_OFS    8'h08
`define VTPA_CTRL_RST    32'h0000_0000
`define VTPA_COUNT_RST   8'h01
`define VTPA_CW_MASK     32'hFF80_0000
`define VTPA_PT_MASK     32'h0F00_0000
`define VTPA_PT_MAX      32'h0300_0000
`define VTPA_FLAG_MASK   8'h4C
`define VTPA_EN_BIT      0
`define VTPA_ABS_BIT     6
`define VTPA_ALIGN_BIT   23
`define VTPA_STAMP_BIT   30
`endif

// file: hdl/vtpa_top.sv
`timescale 1ns/1ps
`include "vtpa_regs.svh"
module vtpa_top import vtpa_pkg::*; (
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // encoder byte stream
  input  wire logic [7:0]  ts_byte_in,
  input  wire logic        ts_valid_in,
  output logic             ts_ready_out,
  // time sources
  input  wire logic [47:0] rtc_in,
  input  wire logic [63:0] abs_time_in,
  // packet body words
  output logic      [15:0] word_out,
  output logic             word_valid_out,
  input  wire logic        word_ready_in,
  output logic             word_first_out,
  output logic             word_last_out,
  output logic      [47:0] hdr_time_out,
  output logic      [7:0]  pkt_flags_out
);
  // ----------------------------------------
  // carriers and state
  // ----------------------------------------
  vtpa_cfg_if  cfg ();               // register side
  vtpa_word_if pk ();                // packed transport words

  vtpa_state_t state_q;              // assembler state
  vtpa_state_t state_d;
  logic [31:0] cw_q;                 // channel word of frame
  logic        abs_q;                // absolute stamps this frame
  logic [1:0]  sidx_q;               // stamp word index
  logic [7:0]  tsn_q;                // transport packet number
  logic [7:0]  errs_q;               // sync drop counter
  logic [6:0]  dcnt_q;               // data words in packet
  logic        emit;                 // load output stage
  logic        latch;                // frame start
  logic [15:0] ow;                   // word to load
  logic        of;                   // first body word
  logic        ol;                   // last body word

  // ----------------------------------------
  // continuous decode
  // ----------------------------------------
  // output stage free or being drained
  wire adv = ~word_valid_out | word_ready_in;
  wire en = cfg.ctrl[`VTPA_EN_BIT];
  wire big = cw_q[`VTPA_ALIGN_BIT];
  wire stamp_en = cw_q[`VTPA_STAMP_BIT];
  // relative stamp keeps its top sixteen bits zero
  wire [63:0] stamp = abs_q ? pk.abs : {16'h0, pk.rel};
  // low long word first, then the high one
  wire [31:0] stamp_lw = sidx_q[1] ? stamp[63:32] : stamp[31:0];
  wire frame_end = (tsn_q == cfg.ts_per_pkt);
  // byte order follows the live register setting while idle, then the latched frame setting
  wire pack_big = (state_q == S_IDLE) ? cfg.ctrl[`VTPA_ALIGN_BIT] : big;

  assign cfg.busy = (state_q != S_IDLE);
  assign cfg.sync_errs = errs_q;

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  vtpa_apb_regs u_regs (
    .clk_in      (mclk_in),
    .rst_n_in    (rst_n_in),
    .psel_in     (psel_in),
    .penable_in  (penable_in),
    .pwrite_in   (pwrite_in),
    .paddr_in    (paddr_in),
    .pwdata_in   (pwdata_in),
    .prdata_out  (prdata_out),
    .pready_out  (pready_out),
    .pslverr_out (pslverr_out),
    .cfg         (cfg)
  );

  vtpa_ts_pack u_pack (
    .clk_in       (mclk_in),
    .rst_n_in     (rst_n_in),
    .ts_byte_in   (ts_byte_in),
    .ts_valid_in  (ts_valid_in),
    .ts_ready_out (ts_ready_out),
    .big_in       (pack_big),
    .rtc_in       (rtc_in),
    .abs_time_in  (abs_time_in),
    .w            (pk)
  );

  // ----------------------------------------
  // next state and word choice
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    emit = 1'b0;
    latch = 1'b0;
    ow = word_out;
    of = 1'b0;
    ol = 1'b0;
    pk.take = 1'b0;
    case (state_q)
      S_IDLE: begin
        // frame opens only once a sync byte has been seen
        if (en && pk.valid && pk.first) begin
          latch = 1'b1;
          state_d = S_CW_LO;
        end
      end
      S_CW_LO: begin
        if (adv) begin
          emit = 1'b1;
          of = 1'b1;
          ow = vtpa_half(cw_q, 1'b0);
          state_d = S_CW_HI;
        end
      end
      S_CW_HI: begin
        if (adv) begin
          emit = 1'b1;
          ow = vtpa_half(cw_q, 1'b1);
          state_d = S_NEXT;
        end
      end
      S_NEXT: begin
        // waits for the next sync so its time is known
        if (pk.valid) begin
          state_d = stamp_en ? S_STAMP : S_DATA;
        end
      end
      S_STAMP: begin
        if (adv) begin
          emit = 1'b1;
          ow = vtpa_half(stamp_lw, sidx_q[0]);
          if (sidx_q == `VTPA_STAMP_LAST) begin
            state_d = S_DATA;
          end
        end
      end
      S_DATA: begin
        if (adv && pk.valid) begin
          emit = 1'b1;
          pk.take = 1'b1;
          ow = pk.word;
          // last word of the last transport packet closes the frame
          if (pk.last) begin
            ol = frame_end;
            state_d = frame_end ? S_IDLE : S_NEXT;
          end
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // assembler registers
  // ----------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= S_IDLE;
      cw_q <= `VTPA_CTRL_RST;
      abs_q <= 1'b0;
      sidx_q <= 2'h0;
      tsn_q <= `VTPA_COUNT_RST;
      dcnt_q <= 7'h00;
    end else begin
      state_q <= state_d;
      if (latch) begin
        // reserved bits masked off here
        cw_q <= cfg.ctrl & `VTPA_CW_MASK;
        abs_q <= cfg.ctrl[`VTPA_ABS_BIT];
        tsn_q <= `VTPA_COUNT_RST;
      end
      if (state_q == S_NEXT) sidx_q <= 2'h0;
      else if (emit && state_q == S_STAMP) sidx_q <= 2'(sidx_q + 2'h1);
      if (pk.take) dcnt_q <= pk.last ? 7'h00 : 7'(dcnt_q + 7'h01);
      if (pk.take && pk.last && !frame_end) tsn_q <= 8'(tsn_q + 8'h01);
    end
  end

  // ----------------------------------------
  // output stage
  // ----------------------------------------
  // every output held in flops; stalls freeze the word
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      word_valid_out <= 1'b0;
      word_out <= 16'h0;
      word_first_out <= 1'b0;
      word_last_out <= 1'b0;
    end else begin
      word_valid_out <= emit | (word_valid_out & ~word_ready_in);
      if (emit) begin
        word_out <= ow;
        word_first_out <= of;
        word_last_out <= ol;
      end
    end
  end

  // ----------------------------------------
  // header side information
  // ----------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hdr_time_out <= 48'h0;
      pkt_flags_out <= 8'h00;
      errs_q <= 8'h00;
    end else begin
      if (latch) hdr_time_out <= pk.rel;
      if (latch) pkt_flags_out <= cfg.ctrl[7:0] & `VTPA_FLAG_MASK;
      // counter saturates rather than wrapping to zero
      if (pk.sync_err && errs_q != `VTPA_ERR_MAX) errs_q <= 8'(errs_q + 8'h01);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  wire hs = word_valid_out & word_ready_in;

  chk_cw_low_zero: assert property (
    word_valid_out && word_first_out |-> word_out == 16'h0)
    else $error("channel word low half not zero");

  chk_cw_fields: assert property (
    (cw_q & ~`VTPA_CW_MASK) == 32'h0 && (cw_q & `VTPA_PT_MASK) <= `VTPA_PT_MAX)
    else $error("channel word reserved field or code");

  chk_cw_order: assert property (
    hs && word_first_out |=> word_valid_out && word_out == cw_q[31:16])
    else $error("channel word high half not next");

  chk_stamp_top: assert property (
    state_q == S_STAMP && sidx_q == `VTPA_STAMP_LAST && adv && !abs_q |=> word_out == 16'h0)
    else $error("relative stamp top not zero");

  chk_stamp_count: assert property (
    state_q == S_DATA && $past(state_q) == S_STAMP |-> $past(sidx_q) == `VTPA_STAMP_LAST)
    else $error("stamp shorter than four words");

  chk_sync_place: assert property (
    pk.take && pk.first |=> (big ? word_out[7:0] : word_out[15:8]) == `VTPA_SYNC)
    else $error("sync byte misplaced");

  chk_ts_length: assert property (
    pk.take && pk.last |-> dcnt_q == `VTPA_WORDS_LAST)
    else $error("transport packet length wrong");

  chk_hold_stall: assert property (
    word_valid_out && !word_ready_in |=> word_valid_out && $stable(word_out))
    else $error("word changed while stalled");

  chk_frame_close: assert property (
    hs && word_last_out |=> state_q == S_IDLE [*2])
    else $error("frame did not close after last word");

  cov_stamped: cover property (state_q == S_STAMP ##[1:8] state_q == S_DATA);
  cov_big_sync: cover property (pk.take && pk.first && big);
  cov_sync_drop: cover property (pk.sync_err);
  cov_frame_end: cover property (hs && word_last_out);
endmodule // vtpa_top

// file: hdl/vtpa_ts_pack.sv
`timescale 1ns/1ps
`include "vtpa_regs.svh"
module vtpa_ts_pack import vtpa_pkg::*; (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [7:0]  ts_byte_in,
  input  wire logic        ts_valid_in,
  output logic             ts_ready_out,
  input  wire logic        big_in,
  input  wire logic [47:0] rtc_in,
  input  wire logic [63:0] abs_time_in,
  vtpa_word_if.src         w
);
  // ----------------------------------------
  // byte intake
  // ----------------------------------------
  logic [7:0] idx_q;     // byte index inside transport packet
  logic       half_q;    // one byte held
  logic [7:0] early_q;   // held earlier byte
  wire  acc     = ts_valid_in & ts_ready_out;
  wire  at_sync = (idx_q == `VTPA_IDX_ZERO);
  wire  bad     = acc & at_sync & (ts_byte_in != `VTPA_SYNC);
  wire  good    = acc & ~bad;
  wire  form    = good & half_q;
  wire  vld_d   = form | (w.valid & ~w.take);
  // single word store, so a new sync byte waits for the last word
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      idx_q <= `VTPA_IDX_ZERO;
      half_q <= 1'b0;
      early_q <= 8'h00;
      ts_ready_out <= 1'b1;
      w.valid <= 1'b0;
      w.word <= 16'h0;
      w.first <= 1'b0;
      w.last <= 1'b0;
      w.rel <= 48'h0;
      w.abs <= 64'h0;
      w.sync_err <= 1'b0;
    end else begin
      ts_ready_out <= ~vld_d;
      w.valid <= vld_d;
      w.sync_err <= bad;
      if (good) begin
        idx_q <= (idx_q == `VTPA_TS_LAST) ? `VTPA_IDX_ZERO : 8'(idx_q + `VTPA_IDX_ONE);
        half_q <= ~half_q;
        early_q <= ts_byte_in;
      end
      if (good && at_sync) begin
        w.rel <= rtc_in;        // time of first bit
        w.abs <= abs_time_in;
      end
      if (form) begin
        w.word <= vtpa_pair(early_q, ts_byte_in, big_in);
        w.first <= (idx_q == `VTPA_IDX_ONE);
        w.last <= (idx_q == `VTPA_TS_LAST);
      end
    end
  end
endmodule // vtpa_ts_pack

// file: verif/test_video_ts_packet_assembler.sv
`timescale 1ns/1ps
`include "vtpa_regs.svh"
module test_video_ts_packet_assembler;
  logic        mclk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [7:0]  paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out;
  logic        pready_out, pslverr_out, ts_ready_out, ts_valid, go = 1'b0, bad = 1'b0, busy;
  logic [7:0]  ts_byte, pkt_flags_out;
  logic [2:0]  npkt = 3'h1;
  logic [47:0] rtc_in = 48'h0, hdr_time_out;
  logic [63:0] abs_time_in = 64'h0;
  logic [15:0] word_out;
  logic        word_valid_out, word_ready_in = 1'b0, word_first_out, word_last_out;
  int          err_total = 0;
  int          cmp_count = 0;
  logic [7:0]  byte_q[$];
  logic [47:0] rtc_q[$];
  logic [17:0] got_q[$], exp_q[$];  // {first, last, word}

  initial begin
    forever #4 mclk_in = ~mclk_in;
  end

  vtpa_top u_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .ts_byte_in(ts_byte), .ts_valid_in(ts_valid),
    .ts_ready_out(ts_ready_out), .rtc_in(rtc_in), .abs_time_in(abs_time_in), .word_out(word_out),
    .word_valid_out(word_valid_out), .word_ready_in(word_ready_in), .word_first_out(word_first_out),
    .word_last_out(word_last_out), .hdr_time_out(hdr_time_out), .pkt_flags_out(pkt_flags_out));

  vtpa_enc_model u_enc (.clk_in(mclk_in), .rst_n_in(rst_n_in), .go_in(go), .npkt_in(npkt), .bad_in(bad),
    .ts_ready_in(ts_ready_out), .ts_byte_out(ts_byte), .ts_valid_out(ts_valid), .busy_out(busy));

  // ----------------------------------------
  // monitors, time base, downstream stalls
  // ----------------------------------------
  always @(posedge mclk_in) begin
    if (ts_valid === 1'b1 && ts_ready_out === 1'b1) begin
      byte_q.push_back(ts_byte);
      rtc_q.push_back(rtc_in);
    end
    if (word_valid_out === 1'b1 && word_ready_in === 1'b1) begin
      got_q.push_back({word_first_out, word_last_out, word_out});
    end
    rtc_in        <= rtc_in + 48'h1;
    word_ready_in <= ($urandom_range(3) != 0);
  end

  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk_w(input logic [17:0] got, input logic [17:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t word got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_v(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t value got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel_in   <= 1'b1;
    pwrite_in <= wr;
    paddr_in  <= a;
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge mclk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      final_report();
    end
    rd = prdata_out;
    err = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
    @(posedge mclk_in);
  endtask

  // expected body words from the bytes the encoder handed over
  task automatic build(input logic [31:0] c, output int drops, output logic [47:0] t0);
    int         idx;
    logic [7:0] prev;
    logic [63:0] st;
    logic [31:0] cw;
    idx = 0;
    drops = 0;
    t0 = 48'h0;
    prev = 8'h00;
    cw = c & 32'hFF80_0000;
    exp_q = {};
    exp_q.push_back({2'b10, cw[15:0]});
    exp_q.push_back({2'b00, cw[31:16]});
    foreach (byte_q[k]) begin
      if (idx == 0 && byte_q[k] !== 8'h47) begin
        drops++;
      end else begin
        if (idx == 0) begin
          if (exp_q.size() == 2) t0 = rtc_q[k];
          st = c[6] ? abs_time_in : {16'h0000, rtc_q[k]};
          if (c[30]) for (int h = 0; h < 4; h++) exp_q.push_back({2'b00, st[16*h +: 16]});
        end
        if (idx % 2 == 1) exp_q.push_back({2'b00, c[23] ? {byte_q[k], prev} : {prev, byte_q[k]}});
        prev = byte_q[k];
        idx = (idx == 187) ? 0 : idx + 1;
      end
    end
    exp_q[exp_q.size()-1][16] = 1'b1;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] rd, c, r;
    logic        err;
    logic [47:0] t0;
    int          drops, tot_drop, n, nw;
    tot_drop = 0;
    void'($urandom(20854));
    repeat (12) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    apb(1'b0, `VTPA_CTRL_OFS, 32'h0, rd, err);
    chk_v(rd, 32'h0);
    apb(1'b0, `VTPA_COUNT_OFS, 32'h0, rd, err);
    chk_v(rd, 32'h1);
    apb(1'b0, `VTPA_STAT_OFS, 32'h0, rd, err);
    chk_v(rd, 32'h0);
    apb(1'b0, 8'h0C, 32'h0, rd, err);          // unmapped place
    chk_v({err, rd}, {1'b1, 32'h0});
    apb(1'b1, `VTPA_CTRL_OFS, 32'h0200_0000, rd, err);
    for (int p = 4; p < 16; p++) begin
      apb(1'b1, `VTPA_CTRL_OFS, 32'h8000_0000 | (32'(p) << 24), rd, err);
      apb(1'b0, `VTPA_CTRL_OFS, 32'h0, rd, err);
      chk_v(rd, 32'h8200_0000);
    end
    apb(1'b1, `VTPA_COUNT_OFS, 32'h0, rd, err);
    apb(1'b0, `VTPA_COUNT_OFS, 32'h0, rd, err);
    chk_v(rd, 32'h1);
    // every payload code twice, both orders, stamps on and off
    for (int i = 0; i < 8; i++) begin
      r = $urandom();
      c = (r & 32'hB07F_FF8C) | (32'(i[1] ^ i[2] ^ 1'b1) << 30) | (32'(i % 4) << 24)
          | (32'(i[0] ^ i[2]) << 23) | (32'(i[2]) << 6) | 32'h1;
      apb(1'b1, `VTPA_CTRL_OFS, c, rd, err);
      apb(1'b1, `VTPA_COUNT_OFS, 32'(i % 3 + 1), rd, err);
      abs_time_in <= {$urandom(), $urandom()};
      byte_q = {};
      rtc_q = {};
      got_q = {};
      npkt <= 3'(i % 3 + 1);
      bad  <= (i == 2);
      go   <= 1'b1;
      @(posedge mclk_in);
      go <= 1'b0;
      nw = 2 + (i % 3 + 1) * (94 + (c[30] ? 4 : 0));
      n = 0;
      do begin
        @(posedge mclk_in);
        n++;
      end while ((busy || got_q.size() < nw) && n < 20000);
      if (n >= 20000) begin
        err_total++;
        final_report();
      end
      repeat (20) @(posedge mclk_in);
      build(c, drops, t0);
      tot_drop += drops;
      chk_v(64'(got_q.size()), 64'(exp_q.size()));
      foreach (exp_q[k]) if (k < got_q.size()) chk_w(got_q[k], exp_q[k]);
      chk_v(hdr_time_out, t0);
      chk_v(pkt_flags_out, c[7:0] & 8'h4C);
    end
    apb(1'b1, `VTPA_STAT_OFS, 32'hFFFF_FFFF, rd, err);
    apb(1'b0, `VTPA_STAT_OFS, 32'h0, rd, err);
    chk_v(rd[8:0], {1'b0, 8'(tot_drop)});
    final_report();
  end
endmodule // test_video_ts_packet_assembler

// file: verif/vtpa_enc_model.sv
`timescale 1ns/1ps
module vtpa_enc_model (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       go_in,       // start a burst
  input  wire logic [2:0] npkt_in,     // transport packets in burst
  input  wire logic       bad_in,      // lead with a false sync byte
  input  wire logic       ts_ready_in,
  output logic      [7:0] ts_byte_out,
  output logic            ts_valid_out,
  output logic            busy_out
);
  int   cnt_q;    // bytes taken so far
  int   total_q;  // bytes in this burst
  int   nxt;      // byte about to be offered
  logic bad_q;    // burst opens with a false sync

  assign busy_out = (cnt_q < total_q);

  // ----------------------------------------
  // byte pacing, held until taken
  // ----------------------------------------
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ts_valid_out <= 1'b0;
      ts_byte_out  <= 8'h00;
      cnt_q        <= 0;
      total_q      <= 0;
      bad_q        <= 1'b0;
    end else if (go_in) begin
      cnt_q   <= 0;
      total_q <= int'(npkt_in) * 188 + int'(bad_in);
      bad_q   <= bad_in;
    end else if (!ts_valid_out || ts_ready_in) begin
      nxt = ts_valid_out ? cnt_q + 1 : cnt_q;
      cnt_q <= nxt;
      // idle slots keep a steady average rate
      if (nxt < total_q && $urandom_range(3) != 0) begin
        ts_valid_out <= 1'b1;
        if (bad_q && nxt == 0) begin
          ts_byte_out <= 8'hB8;  // deliberate false sync
        end else if ((nxt - int'(bad_q)) % 188 == 0) begin
          ts_byte_out <= 8'h47;
        end else begin
          ts_byte_out <= 8'($urandom());
        end
      end else begin
        // released line: never leave the old value standing
        ts_valid_out <= 1'b0;
        ts_byte_out  <= ~ts_byte_out;
      end
    end
  end
endmodule // vtpa_enc_model
